/* File: core/jdp_port.v */
// test access port and background debug serial front end on shared pins
// Overview of operation
// R01 - system keeps all test selects low normally
// R02 - lowest select high means debug, else JTAG
// R03 - float input tristates every output immediately
// R04 - clock/reset pin is debug clock or TRST
// R05 - test selects stable while reset input high
// R06 - TRST low resets TAP, loads BYPASS
// R07 - release TRST only while TMS high
// R08 - pull-ups make TRST, TMS, TDI read high
// R09 - TMS high reaches reset within five clocks
// R10 - debug clock at most one fifth bus clock
// R11 - mode pin is breakpoint or TMS
// R12 - sixteen-state TAP advances on TCK rise
// R13 - breakpoint in debug mode requests processor halt
// R14 - data pin is debug input or TDI
// R15 - TDI shifts into boundary, bypass or instruction
// R16 - debug commands arrive one bit at a time
// R17 - output pin is debug output or TDO
// R18 - unused JTAG: TMS, TDI high, TRST low
// R19 - TDO changes on TCK fall, floats otherwise
`timescale 1ns/100ps
`include "jdp_defines.vh"
module jdp_port #(
  parameter BSR_W = `JDP_BSR_W,
  parameter CMD_W = `JDP_DBG_CMD_W
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // mode pins and test clock
  input  wire [3:0]       test_select,
  input  wire             output_float_n,
  input  wire             reset_input,
  input  wire             tck,
  // shared pins, raw levels; undriven pins read high by pull-up
  input  wire             clk_trst_pin,
  input  wire             mode_brk_pin,
  input  wire             data_in_pin,
  output wire             data_out_pin_o,
  output wire             data_out_pin_oe,
  // boundary scan cells
  input  wire [BSR_W-1:0] bsr_capture,
  output reg  [BSR_W-1:0] bsr_update_ff,
  // debug module side
  output reg  [CMD_W-1:0] dbg_cmd_ff,
  output reg              dbg_cmd_valid_ff,
  input  wire [CMD_W-1:0] dbg_resp,
  output reg              breakpoint_req_ff,
  // status
  output wire             debug_mode,
  output reg  [3:0]       tap_state_ff,
  output reg  [3:0]       ir_ff
);
  // synchronised pins: clock/reset, mode, data, tck
  wire [3:0] s_lvl;
  wire [3:0] s_rise;
  wire [3:0] s_fall;
  jdp_sync #(.W(4)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({tck, data_in_pin, mode_brk_pin, clk_trst_pin}),
    .rst_val (4'hF),  // R08
    .lvl     (s_lvl),
    .rise    (s_rise),
    .fall    (s_fall)
  );
  // mode select latched while reset input low (R05 relied on)
  reg [3:0] sel_ff;
  reg       tsel_s1_ff;
  reg       tsel_r2_ff;  // second stage of the reset input
  reg [3:0] tsel_s1v_ff;
  reg [3:0] tsel_s2_ff;
  always @(posedge clk) begin
    if (sys_rst) begin
      tsel_s1v_ff <= 4'h0;
      tsel_s2_ff  <= 4'h0;
      tsel_s1_ff  <= 1'b0;
      tsel_r2_ff  <= 1'b0;
      sel_ff      <= `JDP_SEL_JTAG;
    end else begin
      tsel_s1v_ff <= test_select;
      tsel_s2_ff  <= tsel_s1v_ff;
      tsel_s1_ff  <= reset_input;
      tsel_r2_ff  <= tsel_s1_ff;
      if (!tsel_r2_ff)
        sel_ff <= tsel_s2_ff;
    end
  end
  // unused test select bits read back only for decode
  wire sel_jtag  = (sel_ff == `JDP_SEL_JTAG);   // R04
  wire sel_debug = (sel_ff == `JDP_SEL_DEBUG);  // R04
  assign debug_mode = sel_ff[0];                // R02
  // pin function decode
  wire trst_n   = sel_jtag ? clk_trst_pin : 1'b1;   // R04 R08 asynchronous path
  wire dclk_r   = sel_debug & s_rise[0];            // R04
  wire dclk_f   = sel_debug & s_fall[0];
  wire tms      = s_lvl[1];                         // R11
  wire brk_n    = sel_debug ? s_lvl[1] : 1'b1;      // R11
  wire din      = s_lvl[2];                         // R14
  wire tck_r    = sel_jtag & s_rise[3];
  wire tck_f    = sel_jtag & s_fall[3];
  // asynchronous TRST: held low forces reset state
  wire tap_rst  = sys_rst | ~trst_n;                // R06
  // tap controller, next state
  reg [3:0] nxt_state;
  always @* begin
    case (tap_state_ff)                             // R12
      `JDP_ST_TLR:    nxt_state = tms ? `JDP_ST_TLR    : `JDP_ST_RTI;
      `JDP_ST_RTI:    nxt_state = tms ? `JDP_ST_SEL_DR : `JDP_ST_RTI;
      `JDP_ST_SEL_DR: nxt_state = tms ? `JDP_ST_SEL_IR : `JDP_ST_CAP_DR;
      `JDP_ST_CAP_DR: nxt_state = tms ? `JDP_ST_EX1_DR : `JDP_ST_SH_DR;
      `JDP_ST_SH_DR:  nxt_state = tms ? `JDP_ST_EX1_DR : `JDP_ST_SH_DR;
      `JDP_ST_EX1_DR: nxt_state = tms ? `JDP_ST_UPD_DR : `JDP_ST_PAU_DR;
      `JDP_ST_PAU_DR: nxt_state = tms ? `JDP_ST_EX2_DR : `JDP_ST_PAU_DR;
      `JDP_ST_EX2_DR: nxt_state = tms ? `JDP_ST_UPD_DR : `JDP_ST_SH_DR;
      `JDP_ST_UPD_DR: nxt_state = tms ? `JDP_ST_SEL_DR : `JDP_ST_RTI;
      `JDP_ST_SEL_IR: nxt_state = tms ? `JDP_ST_TLR    : `JDP_ST_CAP_IR; // R09
      `JDP_ST_CAP_IR: nxt_state = tms ? `JDP_ST_EX1_IR : `JDP_ST_SH_IR;
      `JDP_ST_SH_IR:  nxt_state = tms ? `JDP_ST_EX1_IR : `JDP_ST_SH_IR;
      `JDP_ST_EX1_IR: nxt_state = tms ? `JDP_ST_UPD_IR : `JDP_ST_PAU_IR;
      `JDP_ST_PAU_IR: nxt_state = tms ? `JDP_ST_EX2_IR : `JDP_ST_PAU_IR;
      `JDP_ST_EX2_IR: nxt_state = tms ? `JDP_ST_UPD_IR : `JDP_ST_SH_IR;
      `JDP_ST_UPD_IR: nxt_state = tms ? `JDP_ST_SEL_DR : `JDP_ST_RTI;
      default:        nxt_state = `JDP_ST_TLR;
    endcase
  end
  // shift registers and tap state
  reg [`JDP_IR_W-1:0] ir_sh_ff;   // instruction shift stage
  reg [BSR_W-1:0]     bsr_sh_ff;  // boundary scan chain
  reg                 byp_ff;     // bypass bit
  wire sel_bsr = (ir_ff == `JDP_IR_EXTEST) | (ir_ff == `JDP_IR_SAMPLE);
  always @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      tap_state_ff  <= `JDP_ST_TLR;                 // R06
      ir_ff         <= `JDP_IR_BYPASS;              // R06
      ir_sh_ff      <= `JDP_IR_BYPASS;
      bsr_sh_ff     <= {BSR_W{1'b0}};
      bsr_update_ff <= {BSR_W{1'b0}};
      byp_ff        <= 1'b0;
    end else if (tck_r) begin
      tap_state_ff <= nxt_state;                    // R12
      case (tap_state_ff)
        `JDP_ST_TLR: begin
          ir_ff <= `JDP_IR_BYPASS;                  // R09
        end
        `JDP_ST_CAP_IR: begin
          ir_sh_ff <= `JDP_IR_CAPTURE;
        end
        `JDP_ST_SH_IR: begin
          ir_sh_ff <= {din, ir_sh_ff[`JDP_IR_W-1:1]};   // R15
        end
        `JDP_ST_UPD_IR: begin
          ir_ff <= ir_sh_ff;
        end
        `JDP_ST_CAP_DR: begin
          if (sel_bsr)
            bsr_sh_ff <= bsr_capture;
          else
            byp_ff <= 1'b0;
        end
        `JDP_ST_SH_DR: begin
          if (sel_bsr)
            bsr_sh_ff <= {din, bsr_sh_ff[BSR_W-1:1]};   // R15
          else
            byp_ff <= din;                               // R15
        end
        `JDP_ST_UPD_DR: begin
          if (ir_ff == `JDP_IR_EXTEST)
            bsr_update_ff <= bsr_sh_ff;
        end
        default: begin
          byp_ff <= byp_ff;
        end
      endcase
    end
  end
  // serial output selection
  wire shift_ir = (tap_state_ff == `JDP_ST_SH_IR);
  wire shift_dr = (tap_state_ff == `JDP_ST_SH_DR);
  wire tdo_bit  = shift_ir ? ir_sh_ff[0] : (sel_bsr ? bsr_sh_ff[0] : byp_ff);
  // tdo driven from tck fall, floated outside shift
  reg tdo_ff;
  reg tdo_en_ff;
  always @(posedge clk) begin
    if (sys_rst) begin
      tdo_ff    <= 1'b0;
      tdo_en_ff <= 1'b0;
    end else if (tck_f) begin
      tdo_ff    <= tdo_bit;                         // R19
      tdo_en_ff <= shift_ir | shift_dr;             // R19
    end else if (!sel_jtag) begin
      tdo_en_ff <= 1'b0;
    end
  end
  // debug serial: full duplex shift of CMD_W bits
  reg [CMD_W-1:0] dsi_sh_ff;  // incoming command bits
  reg [CMD_W-1:0] sout_sh_ff; // outgoing response bits
  reg [4:0]       dbit_ff;    // bits received
  reg             sout_ff;
  localparam [31:0] CMD_LAST = CMD_W - 1;  // index of the last command bit
  always @(posedge clk) begin
    if (sys_rst || !sel_debug) begin
      dsi_sh_ff        <= {CMD_W{1'b0}};
      sout_sh_ff       <= {CMD_W{1'b0}};
      dbit_ff          <= 5'h00;
      sout_ff          <= 1'b0;
      dbg_cmd_ff       <= {CMD_W{1'b0}};
      dbg_cmd_valid_ff <= 1'b0;
    end else begin
      dbg_cmd_valid_ff <= 1'b0;
      if (dclk_r) begin
        dsi_sh_ff <= {dsi_sh_ff[CMD_W-2:0], din};   // R16
        if (dbit_ff == CMD_LAST[4:0]) begin
          dbit_ff          <= 5'h00;
          dbg_cmd_ff       <= {dsi_sh_ff[CMD_W-2:0], din};
          dbg_cmd_valid_ff <= 1'b1;
          sout_sh_ff       <= dbg_resp;
        end else begin
          dbit_ff    <= dbit_ff + 5'h01;
          sout_sh_ff <= {sout_sh_ff[CMD_W-2:0], 1'b0};
        end
      end
      if (dclk_f)
        sout_ff <= sout_sh_ff[CMD_W-1];             // R17
    end
  end
  // hardware breakpoint request from low breakpoint_n in debug mode
  always @(posedge clk) begin
    if (sys_rst)
      breakpoint_req_ff <= 1'b0;
    else
      breakpoint_req_ff <= sel_debug & ~brk_n;      // R13
  end
  // output pin mux and asynchronous float
  wire out_val = sel_debug ? sout_ff : tdo_ff;      // R17
  wire out_en  = sel_debug | (sel_jtag & tdo_en_ff);
  assign data_out_pin_o  = out_val;
  assign data_out_pin_oe = out_en & output_float_n; // R03
endmodule

/* File: core/jdp_defines.vh */
// constants for the test and debug pin front end
`ifndef JDP_DEFINES_VH
`define JDP_DEFINES_VH
`define JDP_SEL_JTAG    4'h0
`define JDP_SEL_DEBUG   4'h1
`define JDP_IR_W        4
`define JDP_IR_BYPASS   4'hF
`define JDP_IR_EXTEST   4'h0
`define JDP_IR_SAMPLE   4'h1
`define JDP_IR_CAPTURE  4'h1
`define JDP_BSR_W       8
`define JDP_DBG_CMD_W   17
`define JDP_ST_W        4
`define JDP_ST_TLR      4'h0
`define JDP_ST_RTI      4'h1
`define JDP_ST_SEL_DR   4'h2
`define JDP_ST_CAP_DR   4'h3
`define JDP_ST_SH_DR    4'h4
`define JDP_ST_EX1_DR   4'h5
`define JDP_ST_PAU_DR   4'h6
`define JDP_ST_EX2_DR   4'h7
`define JDP_ST_UPD_DR   4'h8
`define JDP_ST_SEL_IR   4'h9
`define JDP_ST_CAP_IR   4'hA
`define JDP_ST_SH_IR    4'hB
`define JDP_ST_EX1_IR   4'hC
`define JDP_ST_PAU_IR   4'hD
`define JDP_ST_EX2_IR   4'hE
`define JDP_ST_UPD_IR   4'hF
`endif

/* File: core/jdp_sync.v */
// two flip-flop synchroniser with edge detection, one per bit
`timescale 1ns/100ps
module jdp_sync #(
  parameter W = 5
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // raw pins and reset value
  input  wire [W-1:0] pin_in,
  input  wire [W-1:0] rst_val,
  // synchronised level and edges
  output wire [W-1:0] lvl,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_ff;  // first stage, read only by s2
      reg s2_ff;  // stable level
      reg s3_ff;  // previous level for edges
      // shift the pin through the stages
      always @(posedge clk) begin
        if (sys_rst) begin
          s1_ff <= rst_val[i];  // preset to the pin's idle level
          s2_ff <= rst_val[i];
          s3_ff <= rst_val[i];
        end else begin
          s1_ff <= pin_in[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      assign lvl[i]  = s2_ff;
      assign rise[i] = s2_ff & ~s3_ff;
      assign fall[i] = ~s2_ff & s3_ff;
    end
  endgenerate
endmodule

/* File: testbench/jdp_port_checker.sv */
// assertions on the test and debug pin port
`timescale 1ns/100ps
`include "jdp_defines.vh"
module jdp_checker #(
  parameter BSR_W = 8,
  parameter CMD_W = 17
) (
  // clock, reset and pins
  input wire       clk,
  input wire       sys_rst,
  input wire [3:0] test_select,
  input wire       output_float_n,
  input wire       tck,
  input wire       clk_trst_pin,
  input wire       mode_brk_pin,
  input wire       data_out_pin_o,
  input wire       data_out_pin_oe,
  // status outputs
  input wire       dbg_cmd_valid_ff,
  input wire       breakpoint_req_ff,
  input wire       debug_mode,
  input wire [3:0] tap_state_ff,
  input wire [3:0] ir_ff
);
  reg       tck_q_ff;  // raw tck one clock late
  reg [2:0] hi_cnt_ff; // tck rises in a row with tms high
  // count tms-high rises, saturating at five
  always @(posedge clk) begin
    tck_q_ff <= tck;
    if (sys_rst || debug_mode || !mode_brk_pin)
      hi_cnt_ff <= 3'h0;
    else if (tck && !tck_q_ff && hi_cnt_ff != 3'h5)
      hi_cnt_ff <= hi_cnt_ff + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // breakpoint held in debug mode, and plain jtag mode
  sequence brk_held;
    (debug_mode && !mode_brk_pin) [*5];
  endsequence
  sequence jtag_held;
    !debug_mode [*5];
  endsequence
  a_float_kills_oe: assert property (!output_float_n |-> !data_out_pin_oe)
    else $error("output enabled while float asserted");
  a_trst_clears_tap: assert property (!debug_mode && test_select == 4'h0 &&
    !clk_trst_pin |-> tap_state_ff == `JDP_ST_TLR && ir_ff == `JDP_IR_BYPASS)
    else $error("tap not reset under trst");
  a_five_high_tlr: assert property (hi_cnt_ff == 3'h5 |-> ##[0:4]
    tap_state_ff == `JDP_ST_TLR) else $error("tap not in reset after five tms");
  a_oe_in_shift: assert property ($rose(data_out_pin_oe) && !debug_mode |->
    tap_state_ff == `JDP_ST_SH_DR || tap_state_ff == `JDP_ST_SH_IR)
    else $error("output enabled outside shift");
  a_out_on_fall: assert property ($changed(data_out_pin_o) && $stable(debug_mode)
    |-> (debug_mode ? !clk_trst_pin : !tck)) else $error("output moved while clock high");
  a_brk_follows: assert property (brk_held |-> breakpoint_req_ff)
    else $error("breakpoint request missing");
  a_no_brk_jtag: assert property (jtag_held |-> !breakpoint_req_ff)
    else $error("breakpoint request in jtag mode");
  a_debug_holds_tap: assert property (debug_mode [*5] |=> $stable(tap_state_ff))
    else $error("tap moved in debug mode");
  a_cmd_pulse_once: assert property (dbg_cmd_valid_ff |-> debug_mode ##1
    !dbg_cmd_valid_ff) else $error("command valid malformed");
endmodule
bind jdp_port jdp_checker #(.BSR_W(BSR_W), .CMD_W(CMD_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .test_select(test_select),
  .output_float_n(output_float_n), .tck(tck), .clk_trst_pin(clk_trst_pin),
  .mode_brk_pin(mode_brk_pin), .data_out_pin_o(data_out_pin_o),
  .data_out_pin_oe(data_out_pin_oe), .dbg_cmd_valid_ff(dbg_cmd_valid_ff),
  .breakpoint_req_ff(breakpoint_req_ff), .debug_mode(debug_mode),
  .tap_state_ff(tap_state_ff), .ir_ff(ir_ff)
);

/* File: testbench/jdp_probe.sv */
// far-side tester and debug probe model
`timescale 1ns/100ps
module jdp_probe (
  // bench clock
  input  wire clk,
  // pins toward the port
  output reg  tck,
  output reg  rst_pin,
  output reg  mode_pin,
  output reg  din_pin,
  // released-line view of the output pin
  input  wire dout_w
);
  // clocks stand low, trst and data idle high
  initial begin
    tck = 1'b0;
    rst_pin = 1'b1;
    mode_pin = 1'b1;
    din_pin = 1'b1;
  end
  // one 520 ns clock pulse; dbg picks the debug serial clock
  task automatic pulse(input dbg, input m, input d, output o);
    begin
      @(negedge clk);
      mode_pin = m;
      din_pin = d;
      o = dout_w;
      repeat (4) @(negedge clk);
      if (dbg) rst_pin = 1'b1;
      else tck = 1'b1;
      repeat (4) @(negedge clk);
      if (dbg) rst_pin = 1'b0;
      else tck = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  // static levels; trst only released with tms high
  task automatic drive(input r, input m);
    begin
      @(negedge clk);
      mode_pin = m;
      rst_pin = r;
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the test and debug pin port
`timescale 1ns/100ps
`include "jdp_defines.vh"
module testbench;
  reg         clk, sys_rst, output_float_n, reset_input, tdo_q, q;
  reg  [3:0]  test_select, code;
  reg  [7:0]  bsr_capture, data, dout;
  reg  [16:0] dbg_resp, cmd, prev, got;
  wire        tck, rst_pin, mode_pin, din_pin, tdo_o, tdo_oe, vld, brk_req, dmode;
  wire [3:0]  tap_st, ir;
  wire [7:0]  bsr_upd;
  wire [16:0] cmd_out;
  wire        tdo_w = tdo_oe ? tdo_o : ~tdo_q; // released line toggles
  integer     st, i, k, vcnt, cyc, miscompares, tests_run;
  localparam [63:0] NX0 = 64'h1BDDBBA1_46644311; // next state, tms low
  localparam [63:0] NX1 = 64'h2FEFCC02_87855920; // next state, tms high
  jdp_port uut (
    .clk(clk), .sys_rst(sys_rst), .test_select(test_select),
    .output_float_n(output_float_n), .reset_input(reset_input), .tck(tck),
    .clk_trst_pin(rst_pin), .mode_brk_pin(mode_pin), .data_in_pin(din_pin),
    .data_out_pin_o(tdo_o), .data_out_pin_oe(tdo_oe), .bsr_capture(bsr_capture),
    .bsr_update_ff(bsr_upd), .dbg_cmd_ff(cmd_out), .dbg_cmd_valid_ff(vld),
    .dbg_resp(dbg_resp), .breakpoint_req_ff(brk_req), .debug_mode(dmode),
    .tap_state_ff(tap_st), .ir_ff(ir));
  jdp_probe prb (.clk(clk), .tck(tck), .rst_pin(rst_pin), .mode_pin(mode_pin),
    .din_pin(din_pin), .dout_w(tdo_w));
  always #20 clk = ~clk;
  always @(negedge clk) tdo_q <= tdo_w;
  // command pulses and hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (vld === 1'b1) vcnt = vcnt + 1;
    if (cyc == 10000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  task automatic check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one tck step against the state model
  task automatic step(input m, input d, output o);
    begin
      prb.pulse(1'b0, m, d, o);
      st = m ? NX1[st*4+:4] : NX0[st*4+:4];
      check(tap_st, st);
      check(tdo_oe, st == 4 || st == 11);
    end
  endtask
  task automatic walk(input integer n, input [7:0] t);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) step(t[j], 1'b1, q);
    end
  endtask
  // shift n bits lsb first, the last one leaving shift
  task automatic shift(input integer n, input [7:0] din, output [7:0] dq);
    integer j;
    reg     o;
    begin
      for (j = 0; j < n; j = j + 1) begin
        step(j == n - 1, din[j], o);
        dq[j] = o;
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk = 0; sys_rst = 1; test_select = 4'h0; output_float_n = 1; reset_input = 0;
    bsr_capture = 8'h00; dbg_resp = 17'h00000; tdo_q = 0; st = 0;
    vcnt = 0; cyc = 0; miscompares = 0; tests_run = 0;
    void'($urandom(88));
    repeat (5) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    check({ir, tap_st}, 8'hF0);
    for (i = 0; i < 30; i = i + 1) step($urandom % 2, 1'b1, q);
    walk(5, 8'h1F);
    check(tap_st, `JDP_ST_TLR);
    walk(1, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
      code = (k == 2) ? 4'hF : (k == 1) ? 4'h0 : $urandom;
      walk(4, 8'h03);
      shift(4, {4'h0, code}, dout);
      check(dout[3:0], 4'h1);
      walk(2, 8'h01);
      check(ir, code);
      bsr_capture = $urandom;
      data = $urandom;
      walk(3, 8'h01);
      output_float_n = 0;
      #1 check(tdo_oe, 1'b0);
      @(negedge clk) output_float_n = 1;
      shift(8, data, dout);
      check(dout, code <= 1 ? bsr_capture : {data[6:0], 1'b0});
      walk(2, 8'h01);
      if (code == 4'h0) check(bsr_upd, data);
    end
    walk(3, 8'h01);
    prb.drive(1'b0, 1'b1);
    @(negedge clk) st = 0;
    check({ir, tap_st}, 8'hF0);
    prb.drive(1'b1, 1'b1);
    prb.drive(1'b0, 1'b1);
    test_select = `JDP_SEL_DEBUG;
    repeat (4) @(negedge clk);
    check(dmode, 1'b1);
    for (k = 0; k < 2; k = k + 1) begin
      cmd = $urandom;
      prev = dbg_resp;
      dbg_resp = $urandom;
      for (i = 16; i >= 0; i = i - 1) begin
        prb.pulse(1'b1, 1'b1, cmd[i], q);
        got[i] = q;
      end
      check(cmd_out, cmd);
      check(got, prev);
      check(vcnt, k + 1);
    end
    prb.pulse(1'b0, 1'b0, 1'b0, q);
    check(tap_st, `JDP_ST_TLR);
    prb.drive(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    check(brk_req, 1'b1);
    prb.drive(1'b0, 1'b1);
    repeat (5) @(negedge clk);
    check(brk_req, 1'b0);
    close_out;
  end
endmodule
